// ---- core/sphr_regs.sv ----
// host register slice: aux result high byte, parameter mailbox, chip state, analog key
`timescale 1ns/1ps
`default_nettype none
module sphr_regs (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire sphr_pkg::sphr_req_s host_req,
    output logic [7:0] host_rdata_ff,
    output logic host_rvalid_ff,
    input wire sphr_pkg::sphr_pcmd_s param_cmd,
    input wire logic aux_done,
    input wire logic [15:0] aux_result,
    input wire logic aux_int_en,
    input wire sphr_pkg::sphr_pwr_e power_state,
    output logic irq_ff,
    output logic [7:0] aux_result_high_ff,
    output logic [7:0] prox1_input_select,
    output logic [7:0] prox2_input_select,
    output logic [7:0] prox3_input_select,
    output logic [7:0] aux_input_select,
    output logic [31:0] reserved_analog_key_ff
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] param_readback_ff, nxt_param_readback;
    logic [7:0] chip_state_ff, nxt_chip_state;
    logic [7:0] nxt_aux_result_high;
    logic [31:0] nxt_analog_key;
    logic [7:0] nxt_rdata;
    logic nxt_rvalid, nxt_irq;
    logic [7:0] param_mem_ff [sphr_pkg::PARAM_DEPTH];

    // ------------------------------------------------------------
    // host-visible registers
    // ------------------------------------------------------------
    always_comb begin
        nxt_aux_result_high = aux_result_high_ff;
        nxt_param_readback = param_readback_ff;
        nxt_analog_key = reserved_analog_key_ff;
        if (host_req.wr) begin
            case (host_req.addr)
                sphr_pkg::AUX_RESULT_HIGH_OFS: nxt_aux_result_high = host_req.wdata;
                sphr_pkg::PARAM_READBACK_OFS: nxt_param_readback = host_req.wdata;
                sphr_pkg::ANALOG_KEY_OFS_B3: nxt_analog_key[31:24] = host_req.wdata;
                sphr_pkg::ANALOG_KEY_OFS_B2: nxt_analog_key[23:16] = host_req.wdata;
                sphr_pkg::ANALOG_KEY_OFS_B1: nxt_analog_key[15:8] = host_req.wdata;
                sphr_pkg::ANALOG_KEY_OFS_B0: nxt_analog_key[7:0] = host_req.wdata;
                default: nxt_analog_key = reserved_analog_key_ff;
            endcase
        end
        // a completed measurement beats a host write in the same cycle
        if (aux_done) begin
            nxt_aux_result_high = aux_result[15:8];
        end
        // sequencer fetch or store echoes the parameter into the mailbox
        if (param_cmd.valid) begin
            if (param_cmd.store) begin
                nxt_param_readback = param_cmd.data;
            end else begin
                nxt_param_readback = param_mem_ff[param_cmd.addr];
            end
        end
    end

    // ------------------------------------------------------------
    // chip state, interrupt and read path
    // ------------------------------------------------------------
    always_comb begin
        nxt_chip_state = sphr_pkg::BYTE_RESET;
        case (power_state)
            sphr_pkg::PWR_AWAKE: nxt_chip_state[sphr_pkg::AWAKE_FLAG_BIT] = 1'b1;
            sphr_pkg::PWR_SUSPEND: nxt_chip_state[sphr_pkg::SUSPEND_FLAG_BIT] = 1'b1;
            sphr_pkg::PWR_SLEEP: nxt_chip_state[sphr_pkg::SLEEP_FLAG_BIT] = 1'b1;
            default: nxt_chip_state = sphr_pkg::BYTE_RESET;
        endcase
        // level interrupt held until the host reads the aux high byte; new event wins
        nxt_irq = irq_ff;
        if (host_req.rd && host_req.addr == sphr_pkg::AUX_RESULT_HIGH_OFS) begin
            nxt_irq = 1'b0;
        end
        if (aux_done && aux_int_en) begin
            nxt_irq = 1'b1;
        end
        nxt_rvalid = host_req.rd;
        nxt_rdata = host_rdata_ff;
        if (host_req.rd) begin
            case (host_req.addr)
                sphr_pkg::AUX_RESULT_HIGH_OFS: nxt_rdata = aux_result_high_ff;
                sphr_pkg::PARAM_READBACK_OFS: nxt_rdata = param_readback_ff;
                sphr_pkg::CHIP_STATE_FLAGS_OFS: nxt_rdata = chip_state_ff;
                sphr_pkg::ANALOG_KEY_OFS_B3: nxt_rdata = reserved_analog_key_ff[31:24];
                sphr_pkg::ANALOG_KEY_OFS_B2: nxt_rdata = reserved_analog_key_ff[23:16];
                sphr_pkg::ANALOG_KEY_OFS_B1: nxt_rdata = reserved_analog_key_ff[15:8];
                sphr_pkg::ANALOG_KEY_OFS_B0: nxt_rdata = reserved_analog_key_ff[7:0];
                // parameter memory has no host address, so it reads as unmapped
                default: nxt_rdata = sphr_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aux_result_high_ff <= sphr_pkg::BYTE_RESET;
            param_readback_ff <= sphr_pkg::BYTE_RESET;
            chip_state_ff <= sphr_pkg::BYTE_RESET;
            reserved_analog_key_ff <= sphr_pkg::ANALOG_KEY_RESET;
            host_rdata_ff <= sphr_pkg::BYTE_RESET;
            host_rvalid_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            aux_result_high_ff <= nxt_aux_result_high;
            param_readback_ff <= nxt_param_readback;
            chip_state_ff <= nxt_chip_state;
            reserved_analog_key_ff <= nxt_analog_key;
            host_rdata_ff <= nxt_rdata;
            host_rvalid_ff <= nxt_rvalid;
            irq_ff <= nxt_irq;
        end
    end

    // ------------------------------------------------------------
    // parameter memory, written only by the store command
    // ------------------------------------------------------------
    for (genvar i = 0; i < sphr_pkg::PARAM_DEPTH; i++) begin : g_param
        logic [7:0] nxt_entry;
        logic [7:0] entry_default;
        always_comb begin
            entry_default = sphr_pkg::PARAM_DEFAULT;
            if (5'(i) == sphr_pkg::RSVD_0D_IDX) begin
                entry_default = sphr_pkg::RSVD_0D_DEFAULT;
            end
            if (5'(i) == sphr_pkg::RSVD_13_IDX) begin
                entry_default = sphr_pkg::RSVD_13_DEFAULT;
            end
            nxt_entry = param_mem_ff[i];
            if (param_cmd.valid && param_cmd.store && param_cmd.addr == 5'(i)) begin
                nxt_entry = param_cmd.data;
            end
        end
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                param_mem_ff[i] <= entry_default;
            end else begin
                param_mem_ff[i] <= nxt_entry;
            end
        end
    end

    // input selects are taken straight from the memory flops
    assign prox1_input_select = param_mem_ff[sphr_pkg::PROX1_INPUT_SELECT_IDX];
    assign prox2_input_select = param_mem_ff[sphr_pkg::PROX2_INPUT_SELECT_IDX];
    assign prox3_input_select = param_mem_ff[sphr_pkg::PROX3_INPUT_SELECT_IDX];
    assign aux_input_select = param_mem_ff[sphr_pkg::AUX_INPUT_SELECT_IDX];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_aux_high;
        @(posedge sys_clk) disable iff (!rst_n)
        aux_done |=> aux_result_high_ff == $past(aux_result[15:8]);
    endproperty
    a_aux_high: assert property (p_aux_high) else $error("aux high byte not loaded");

    property p_mailbox;
        @(posedge sys_clk) disable iff (!rst_n)
        (param_cmd.valid && !param_cmd.store)
            |=> param_readback_ff == $past(param_mem_ff[param_cmd.addr]);
    endproperty
    a_mailbox: assert property (p_mailbox) else $error("mailbox missed fetched value");

    property p_awake;
        @(posedge sys_clk) disable iff (!rst_n)
        power_state == sphr_pkg::PWR_AWAKE |=> chip_state_ff == 8'h04;
    endproperty
    a_awake: assert property (p_awake) else $error("awake flag wrong");

    property p_suspend;
        @(posedge sys_clk) disable iff (!rst_n)
        power_state == sphr_pkg::PWR_SUSPEND |=> chip_state_ff == 8'h02;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend flag wrong");

    property p_sleep;
        @(posedge sys_clk) disable iff (!rst_n)
        power_state == sphr_pkg::PWR_SLEEP
            |=> chip_state_ff == 8'h01 && chip_state_ff[7:3] == 5'h00;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flag wrong");

    property p_store;
        @(posedge sys_clk) disable iff (!rst_n)
        (param_cmd.valid && param_cmd.store && param_cmd.addr == sphr_pkg::AUX_INPUT_SELECT_IDX)
            |=> aux_input_select == $past(param_cmd.data);
    endproperty
    a_store: assert property (p_store) else $error("aux input select not stored");

    property p_no_bus_param;
        @(posedge sys_clk) disable iff (!rst_n)
        (!param_cmd.valid && !$past(param_cmd.valid)) |-> $stable(prox1_input_select);
    endproperty
    a_no_bus_param: assert property (p_no_bus_param) else $error("stray param change");

    property p_irq;
        @(posedge sys_clk) disable iff (!rst_n)
        (aux_done && aux_int_en) |=> irq_ff ##0 aux_result_high_ff == $past(aux_result[15:8]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing after measurement");
endmodule
`default_nettype wire

// ---- core/sphr_pkg.sv ----
// constants and carrier types for the sensor host status and parameter register slice
package sphr_pkg;
    // ------------------------------------------------------------
    // register offsets (host byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] AUX_RESULT_HIGH_OFS = 8'h2D;
    localparam logic [7:0] PARAM_READBACK_OFS = 8'h2E;
    localparam logic [7:0] CHIP_STATE_FLAGS_OFS = 8'h30;
    localparam logic [7:0] ANALOG_KEY_OFS_B3 = 8'h3B;
    localparam logic [7:0] ANALOG_KEY_OFS_B2 = 8'h3C;
    localparam logic [7:0] ANALOG_KEY_OFS_B1 = 8'h3D;
    localparam logic [7:0] ANALOG_KEY_OFS_B0 = 8'h3E;
    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] ANALOG_KEY_RESET = 32'h00000000;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int AWAKE_FLAG_BIT = 2;
    localparam int SUSPEND_FLAG_BIT = 1;
    localparam int SLEEP_FLAG_BIT = 0;
    // ------------------------------------------------------------
    // parameter memory layout
    // ------------------------------------------------------------
    localparam int PARAM_AW = 5;
    localparam int PARAM_DEPTH = 32;
    localparam logic [4:0] PROX1_INPUT_SELECT_IDX = 5'h07;
    localparam logic [4:0] PROX2_INPUT_SELECT_IDX = 5'h08;
    localparam logic [4:0] PROX3_INPUT_SELECT_IDX = 5'h09;
    localparam logic [4:0] AUX_INPUT_SELECT_IDX = 5'h0F;
    localparam logic [4:0] RSVD_0D_IDX = 5'h0D;
    localparam logic [4:0] RSVD_13_IDX = 5'h13;
    localparam logic [7:0] RSVD_0D_DEFAULT = 8'h02;
    localparam logic [7:0] RSVD_13_DEFAULT = 8'h40;
    localparam logic [7:0] PARAM_DEFAULT = 8'h00;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_AWAKE,
        PWR_SUSPEND,
        PWR_SLEEP
    } sphr_pwr_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sphr_req_s;

    typedef struct packed {
        logic valid;
        logic store;
        logic [4:0] addr;
        logic [7:0] data;
    } sphr_pcmd_s;
endpackage

// ---- testbench/sphr_host_model.sv ----
// host processor model driving the byte register port of the slice
`timescale 1ns/1ps
`default_nettype none
module sphr_host_model (
    input wire logic sys_clk,
    output var sphr_pkg::sphr_req_s host_req,
    input wire logic [7:0] host_rdata_ff,
    input wire logic host_rvalid_ff
);
    initial host_req = '0;
    // a released bus shows the inverse address and data with both strobes low, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge sys_clk);
        host_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    // parameters are never addressed here, only through commands
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk);
        host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge sys_clk);
        host_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        d = host_rdata_ff;
        v = host_rvalid_ff;
    endtask
endmodule
`default_nettype wire

// ---- testbench/sensor_host_status_param_regs_tb_top.sv ----
// self-checking bench for the status and parameter register slice
`timescale 1ns/1ps
`default_nettype none
module sensor_host_status_param_regs_tb_top;
    logic sys_clk, rst_n, aux_done, aux_int_en, host_rvalid_ff, irq_ff, v;
    sphr_pkg::sphr_req_s host_req;
    sphr_pkg::sphr_pcmd_s param_cmd;
    sphr_pkg::sphr_pwr_e power_state;
    logic [15:0] aux_result, r;
    logic [7:0] host_rdata_ff, aux_result_high_ff, sel1, sel2, sel3, sela, d;
    logic [7:0] pv [4];
    logic [4:0] idx [4] = '{5'h07, 5'h08, 5'h09, 5'h0F};
    logic [31:0] key, seed, key_ff;
    int err_count, n_compared, i;
    sphr_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .host_req(host_req),
        .host_rdata_ff(host_rdata_ff), .host_rvalid_ff(host_rvalid_ff),
        .param_cmd(param_cmd), .aux_done(aux_done), .aux_result(aux_result),
        .aux_int_en(aux_int_en), .power_state(power_state), .irq_ff(irq_ff),
        .aux_result_high_ff(aux_result_high_ff), .prox1_input_select(sel1),
        .prox2_input_select(sel2), .prox3_input_select(sel3),
        .aux_input_select(sela), .reserved_analog_key_ff(key_ff));
    sphr_host_model u_host (.sys_clk(sys_clk), .host_req(host_req),
        .host_rdata_ff(host_rdata_ff), .host_rvalid_ff(host_rvalid_ff));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] state_code(input sphr_pkg::sphr_pwr_e p);
        return (p == sphr_pkg::PWR_AWAKE) ? 8'h04 : (p == sphr_pkg::PWR_SUSPEND) ? 8'h02 :
            (p == sphr_pkg::PWR_SLEEP) ? 8'h01 : 8'h00;
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hrd(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d, v);
        chk8({7'h00, v}, 8'h01);
        chk8(d, exp);
    endtask
    task automatic pcmd(input logic st, input logic [4:0] a, input logic [7:0] dv);
        @(negedge sys_clk);
        param_cmd <= '{valid: 1'b1, store: st, addr: a, data: dv};
        @(negedge sys_clk);
        param_cmd <= '{valid: 1'b0, store: ~st, addr: ~a, data: ~dv};
    endtask
    task automatic aux_pulse(input logic [15:0] res, input logic en);
        @(negedge sys_clk);
        aux_done <= 1'b1;
        aux_result <= res;
        aux_int_en <= en;
        @(negedge sys_clk);
        aux_done <= 1'b0;
        aux_result <= ~res;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // a hang anywhere ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 32'hA94373D1;
        rst_n = 1'b0;
        aux_done = 1'b0;
        aux_int_en = 1'b0;
        aux_result = 16'h0000;
        param_cmd = '0;
        power_state = sphr_pkg::PWR_OFF;
        repeat (8) @(negedge sys_clk);
        rst_n <= 1'b1;
        hrd(8'h2D, 8'h00);
        hrd(8'h2E, 8'h00);
        hrd(8'h30, 8'h00);
        for (i = 0; i < 4; i++) hrd(8'h3B + 8'(i), 8'h00);
        chk8(sel1 | sel2 | sel3 | sela, 8'h00);
        $display("test reset done");
        for (i = 3; i >= 0; i--) begin
            @(negedge sys_clk);
            power_state <= sphr_pkg::sphr_pwr_e'(i);
            hrd(8'h30, state_code(sphr_pkg::sphr_pwr_e'(i)));
        end
        u_host.wr(8'h30, 8'hFF);
        hrd(8'h30, 8'h00);
        $display("test chip state done");
        for (i = 0; i < 4; i++) begin
            r = {rnd8(), rnd8()};
            aux_pulse(r, i != 0);
            chk8({7'h00, irq_ff}, {7'h00, i != 0});
            chk8(aux_result_high_ff, r[15:8]);
            hrd(8'h2D, r[15:8]); // read before the next measurement
            chk8({7'h00, irq_ff}, 8'h00);
        end
        $display("test aux result done");
        u_host.wr(8'h2D, 8'h5A);
        hrd(8'h2D, 8'h5A);
        u_host.wr(8'h2E, 8'hC3);
        hrd(8'h2E, 8'hC3);
        r = {rnd8(), rnd8()};
        // measurement and host write in one cycle: the measurement wins
        fork
            u_host.wr(8'h2D, ~r[15:8]);
            aux_pulse(r, 1'b1);
        join
        chk8(aux_result_high_ff, r[15:8]);
        // read and new measurement in one cycle: the interrupt stays set
        fork
            u_host.rd(8'h2D, d, v);
            aux_pulse(~r, 1'b1);
        join
        chk8(d, r[15:8]);
        chk8({7'h00, irq_ff}, 8'h01);
        hrd(8'h2D, ~r[15:8]);
        chk8({7'h00, irq_ff}, 8'h00);
        $display("test collisions done");
        for (i = 0; i < 4; i++) begin
            pv[i] = rnd8();
            pcmd(1'b1, idx[i], pv[i]); // reserved entries left alone
            hrd(8'h2E, pv[i]);
        end
        chk8(sel1, pv[0]);
        chk8(sel2, pv[1]);
        chk8(sel3, pv[2]);
        chk8(sela, pv[3]);
        pcmd(1'b0, 5'h09, rnd8());
        hrd(8'h2E, pv[2]);
        pcmd(1'b0, 5'h0D, rnd8());
        hrd(8'h2E, 8'h02);
        pcmd(1'b0, 5'h13, rnd8());
        hrd(8'h2E, 8'h40);
        hrd(8'h07, 8'h00);
        $display("test parameters done");
        for (i = 0; i < 4; i++) begin
            key[31 - 8 * i -: 8] = rnd8();
            u_host.wr(8'h3B + 8'(i), key[31 - 8 * i -: 8]);
        end
        for (i = 0; i < 4; i++) begin
            hrd(8'h3B + 8'(i), key[31 - 8 * i -: 8]);
            chk8(key_ff[8 * i +: 8], key[8 * i +: 8]);
        end
        $display("test analog key done");
        @(negedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i++) hrd(8'h3B + 8'(i), 8'h00);
        hrd(8'h2D, 8'h00);
        hrd(8'h2E, 8'h00);
        chk8({7'h00, irq_ff}, 8'h00);
        chk8(sel1 | sel2 | sel3 | sela, 8'h00);
        pcmd(1'b0, 5'h13, 8'h00);
        hrd(8'h2E, 8'h40);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
